/* File: src/gpio_pkg.sv */
package gpio_pkg;

	// =========================================================
	// pad population
	localparam int PAD_COUNT    = 10;
	localparam int IND_PAD      = 0;
	localparam int BOOT_PAD     = 7;
	localparam int WAKE_PAD_A   = 0;
	localparam int WAKE_PAD_B   = 3;
	localparam int WAKE_PAD_C   = 4;
	localparam int WAKE_PAD_D   = 7;

	// =========================================================
	// register port
	localparam int              ADDR_W      = 8;
	localparam int              DATA_W      = 32;
	localparam logic [ADDR_W-1:0] OFS_MODE    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_OUT     = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_LEVEL   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_EVT_EN  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_EVENT   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_WAKE_EN = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h18;

	// control register fields
	localparam int STATE_LSB     = 0;
	localparam int STATE_W       = 3;
	localparam int BOOT_BIT      = 8;
	localparam int THERM_EN_BIT  = 12;
	localparam int ALARM_SEL_LSB = 16;
	localparam int ALARM_SEL_W   = 4;
	localparam logic [ALARM_SEL_W-1:0] ALARM_SEL_RST = 4'h1;

	// =========================================================
	// modes and states
	typedef enum logic [1:0] {
		MODE_IN  = 2'h0,
		MODE_OUT = 2'h1,
		MODE_ALT = 2'h2
	} pad_mode_t;

	typedef enum logic [2:0] {
		DEV_OFF         = 3'h0,
		DEV_SEARCH      = 3'h1,
		DEV_UNREG       = 3'h2,
		DEV_REGISTERED  = 3'h3,
		DEV_CALL        = 3'h4,
		DEV_TURNING_OFF = 3'h5
	} dev_state_t;

	typedef enum logic [1:0] {
		PAT_OFF  = 2'h0,
		PAT_FAST = 2'h1,
		PAT_SLOW = 2'h3,
		PAT_ON   = 2'h2
	} pattern_t;

	// =========================================================
	// timing
	localparam int CLK_PERIOD_NS  = 4;
	localparam int TICK_NS        = 1000000;
	localparam int TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
	localparam int FAST_PERIOD_MS = 1000;
	localparam int FAST_ON_MS     = 500;
	localparam int SLOW_PERIOD_MS = 3000;
	localparam int SLOW_ON_MS     = 300;
	localparam int MS_W           = 12;

endpackage : gpio_pkg

/* File: src/pad_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pad_sync #(
	parameter int WIDTH = 10
) (
	input  wire logic             clk,     // system clock
	input  wire logic             rst_n,   // async reset, active low
	input  wire logic [WIDTH-1:0] raw,     // pad levels from outside
	output logic      [WIDTH-1:0] level,   // filtered level
	output logic      [WIDTH-1:0] changed  // one-cycle pulse on change
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] next_level;
	logic [WIDTH-1:0] next_changed;

	// =========================================================
	// settle: a change counts once stages two and three agree
	always_comb begin
		next_level   = level;
		next_changed = '0;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2[i] == s3[i] && s3[i] != level[i]) begin
				next_level[i]   = s3[i];
				next_changed[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1      <= '0;
			s2      <= '0;
			s3      <= '0;
			level   <= '0;
			changed <= '0;
		end else begin
			s1      <= raw;
			s2      <= s1;
			s3      <= s2;
			level   <= next_level;
			changed <= next_changed;
		end
	end
endmodule : pad_sync
`default_nettype wire

/* File: src/status_blinker.sv */
`timescale 1ns/1ps
`default_nettype none
module status_blinker
	import gpio_pkg::*;
(
	input  wire logic       clk,       // system clock
	input  wire logic       rst_n,     // async reset, active low
	input  wire logic       ms_tick,   // one pulse per millisecond
	input  wire gpio_pkg::dev_state_t dev_state, // state to indicate
	output logic            led        // indicator level
);
	import gpio_pkg::*;

	pattern_t         pattern;
	pattern_t         next_pattern;
	pattern_t         want;
	logic [MS_W-1:0]  ms_count;
	logic [MS_W-1:0]  next_ms_count;
	logic [MS_W-1:0]  period;

	// =========================================================
	// pattern selection and phase counter
	always_comb begin
		case (dev_state)
			DEV_OFF:         want = PAT_OFF;
			DEV_CALL:        want = PAT_ON;
			DEV_REGISTERED:  want = PAT_SLOW;
			DEV_SEARCH,
			DEV_UNREG,
			DEV_TURNING_OFF: want = PAT_FAST;
			default:         want = PAT_OFF;
		endcase
		period = (pattern == PAT_SLOW) ? MS_W'(SLOW_PERIOD_MS) : MS_W'(FAST_PERIOD_MS);
		next_pattern  = want;
		next_ms_count = ms_count;
		if (want != pattern) begin
			next_ms_count = '0;
		end else if (ms_tick) begin
			next_ms_count = (ms_count == period - 1'b1) ? '0 : ms_count + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pattern  <= PAT_OFF;
			ms_count <= '0;
		end else begin
			pattern  <= next_pattern;
			ms_count <= next_ms_count;
		end
	end

	always_comb begin
		case (pattern)
			PAT_OFF:  led = 1'b0;
			PAT_ON:   led = 1'b1;
			PAT_FAST: led = (ms_count < MS_W'(FAST_ON_MS));
			PAT_SLOW: led = (ms_count < MS_W'(SLOW_ON_MS));
			default:  led = 1'b0;
		endcase
	end
endmodule : status_blinker
`default_nettype wire

/* File: src/gpio_status_unit.sv */
// Operation
// - each pad is input, output or alternate
// - input pads report the pad level
// - input pad activity raises a software event
// - only pads 1, 4, 5, 8 wake
// - output pads drive high and low
// - pad one defaults to network status indicator
// - indicator off when off, on in call
// - search/unregistered/turning off: 1 s, 0.5 s on
// - registered: 3 s period, 0.3 s on
// - boot indicator low until boot done, then high
// - pad eight defaults to boot-complete indicator
// - thermal alarm drives its assigned pad high
`timescale 1ns/1ps
`default_nettype none
module gpio_status_unit
	import gpio_pkg::*;
#(
	parameter int PADS       = PAD_COUNT,
	parameter int TICK_CYC   = TICK_CYCLES
) (
	input  wire logic                      clk,         // 250 MHz clock
	input  wire logic                      rst_n,       // async reset, active low
	input  wire logic [gpio_pkg::ADDR_W-1:0] addr,      // register byte address
	input  wire logic [gpio_pkg::DATA_W-1:0] wdata,     // write data
	input  wire logic                      wr,          // write strobe
	input  wire logic                      rd,          // read strobe
	output logic      [gpio_pkg::DATA_W-1:0] rdata,     // read data, cycle after rd
	input  wire logic [PADS-1:0]           pad_in,      // pad input levels
	output logic      [PADS-1:0]           pad_out,     // pad output levels
	output logic      [PADS-1:0]           pad_oe,      // pad drive enables
	input  wire logic [PADS-1:0]           alt_data,    // internal alternate data
	input  wire logic [PADS-1:0]           alt_en,      // internal alternate enable
	input  wire logic                      asleep,      // module in sleep
	input  wire logic                      temp_max,    // maximum temperature reached
	output logic                           wake_request // one-cycle wake pulse
);
	import gpio_pkg::*;

	// =========================================================
	// helpers
	function automatic pad_mode_t mode_of(input logic [2*PADS-1:0] m, input int i);
		logic [1:0] f;
		f = m[2*i +: 2];
		case (f)
			MODE_OUT: mode_of = MODE_OUT;
			MODE_ALT: mode_of = MODE_ALT;
			default:  mode_of = MODE_IN;
		endcase
	endfunction : mode_of

	function automatic logic [2*PADS-1:0] mode_reset();
		logic [2*PADS-1:0] m;
		m = '0;
		m[2*IND_PAD +: 2]  = MODE_ALT;
		m[2*BOOT_PAD +: 2] = MODE_ALT;
		return m;
	endfunction : mode_reset

	function automatic logic [PADS-1:0] wake_mask();
		logic [PADS-1:0] w;
		w = '0;
		w[WAKE_PAD_A] = 1'b1;
		w[WAKE_PAD_B] = 1'b1;
		w[WAKE_PAD_C] = 1'b1;
		w[WAKE_PAD_D] = 1'b1;
		return w;
	endfunction : wake_mask

	localparam logic [2*PADS-1:0] MODE_RST  = mode_reset();
	localparam logic [PADS-1:0]   WAKE_MASK = wake_mask();
	localparam int                TICK_W    = $clog2(TICK_CYC);

	// =========================================================
	// state
	logic [2*PADS-1:0]      mode;
	logic [2*PADS-1:0]      next_mode;
	logic [PADS-1:0]        out_data;
	logic [PADS-1:0]        next_out_data;
	logic [PADS-1:0]        evt_en;
	logic [PADS-1:0]        next_evt_en;
	logic [PADS-1:0]        event_flag;
	logic [PADS-1:0]        next_event_flag;
	logic [PADS-1:0]        wake_en;
	logic [PADS-1:0]        next_wake_en;
	dev_state_t             dev_state;
	dev_state_t             next_dev_state;
	logic                   boot_done;
	logic                   next_boot_done;
	logic                   therm_en;
	logic                   next_therm_en;
	logic [ALARM_SEL_W-1:0] alarm_sel;
	logic [ALARM_SEL_W-1:0] next_alarm_sel;
	logic [DATA_W-1:0]      next_rdata;
	logic [PADS-1:0]        next_pad_out;
	logic [PADS-1:0]        next_pad_oe;
	logic                   next_wake_request;
	logic [TICK_W-1:0]      tick_count;
	logic [TICK_W-1:0]      next_tick_count;
	logic                   ms_tick;
	logic [PADS-1:0]        level;
	logic [PADS-1:0]        changed;
	logic [PADS-1:0]        is_input;
	logic                   ind_led;
	logic                   alarm_on;

	// =========================================================
	// pad input conditioning
	pad_sync #(
		.WIDTH(PADS)
	) i_pad_sync (
		.clk    (clk),
		.rst_n  (rst_n),
		.raw    (pad_in),
		.level  (level),
		.changed(changed)
	);

	// =========================================================
	// millisecond tick for the indicator
	always_comb begin
		ms_tick         = (tick_count == TICK_W'(TICK_CYC - 1));
		next_tick_count = ms_tick ? '0 : tick_count + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_count <= '0;
		end else begin
			tick_count <= next_tick_count;
		end
	end

	status_blinker i_status_blinker (
		.clk      (clk),
		.rst_n    (rst_n),
		.ms_tick  (ms_tick),
		.dev_state(dev_state),
		.led      (ind_led)
	);

	// =========================================================
	// register file
	always_comb begin
		for (int i = 0; i < PADS; i++) begin
			is_input[i] = (mode_of(mode, i) == MODE_IN);
		end
	end

	// the boot bit is only reported; commands that arrive before it is set
	// are not refused here, the host has to wait for the indicator itself
	always_comb begin
		next_mode      = mode;
		next_out_data  = out_data;
		next_evt_en    = evt_en;
		next_wake_en   = wake_en;
		next_dev_state = dev_state;
		next_boot_done = boot_done;
		next_therm_en  = therm_en;
		next_alarm_sel = alarm_sel;
		if (wr) begin
			case (addr)
				OFS_MODE:    next_mode     = wdata[2*PADS-1:0];
				OFS_OUT:     next_out_data = wdata[PADS-1:0];
				OFS_EVT_EN:  next_evt_en   = wdata[PADS-1:0];
				OFS_WAKE_EN: next_wake_en  = wdata[PADS-1:0] & WAKE_MASK;
				OFS_CTRL: begin
					next_dev_state = dev_state_t'(wdata[STATE_LSB +: STATE_W]);
					next_boot_done = wdata[BOOT_BIT];
					next_therm_en  = wdata[THERM_EN_BIT];
					next_alarm_sel = wdata[ALARM_SEL_LSB +: ALARM_SEL_W];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode       <= MODE_RST;
			out_data   <= '0;
			evt_en     <= '0;
			wake_en    <= '0;
			dev_state  <= DEV_OFF;
			boot_done  <= 1'b0;
			therm_en   <= 1'b0;
			alarm_sel  <= ALARM_SEL_RST;
		end else begin
			mode       <= next_mode;
			out_data   <= next_out_data;
			evt_en     <= next_evt_en;
			wake_en    <= next_wake_en;
			dev_state  <= next_dev_state;
			boot_done  <= next_boot_done;
			therm_en   <= next_therm_en;
			alarm_sel  <= next_alarm_sel;
		end
	end

	// =========================================================
	// event flags
	// a new event wins over a clear in the same cycle, so no edge is lost
	always_comb begin
		next_event_flag = event_flag;
		if (wr && addr == OFS_EVENT) begin
			next_event_flag = event_flag & ~wdata[PADS-1:0];
		end
		next_event_flag = next_event_flag | (changed & is_input & evt_en);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			event_flag <= '0;
		end else begin
			event_flag <= next_event_flag;
		end
	end

	// =========================================================
	// read port
	// zero outside its single cycle, so stale data never lingers on the bus
	always_comb begin
		next_rdata = '0;
		if (rd) begin
			case (addr)
				OFS_MODE:    next_rdata[2*PADS-1:0] = mode;
				OFS_OUT:     next_rdata[PADS-1:0]   = out_data;
				OFS_LEVEL:   next_rdata[PADS-1:0]   = level;
				OFS_EVT_EN:  next_rdata[PADS-1:0]   = evt_en;
				OFS_EVENT:   next_rdata[PADS-1:0]   = event_flag;
				OFS_WAKE_EN: next_rdata[PADS-1:0]   = wake_en;
				OFS_CTRL: begin
					next_rdata[STATE_LSB +: STATE_W]         = dev_state;
					next_rdata[BOOT_BIT]                     = boot_done;
					next_rdata[THERM_EN_BIT]                 = therm_en;
					next_rdata[ALARM_SEL_LSB +: ALARM_SEL_W] = alarm_sel;
				end
				default:     next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end

	// =========================================================
	// pad drive and wake
	// the alarm overrides whatever mode its pad is in, so a hot part
	// is signalled even when software left the pad as an input
	always_comb begin
		alarm_on = therm_en & temp_max;
		for (int i = 0; i < PADS; i++) begin
			next_pad_out[i] = 1'b0;
			next_pad_oe[i]  = 1'b0;
			if (alarm_on && alarm_sel == ALARM_SEL_W'(i)) begin
				next_pad_out[i] = 1'b1;
				next_pad_oe[i]  = 1'b1;
			end else begin
				case (mode_of(mode, i))
					MODE_OUT: begin
						next_pad_out[i] = out_data[i];
						next_pad_oe[i]  = 1'b1;
					end
					MODE_ALT: begin
						if (i == IND_PAD) begin
							next_pad_out[i] = ind_led;
							next_pad_oe[i]  = 1'b1;
						end else if (i == BOOT_PAD) begin
							next_pad_out[i] = boot_done;
							next_pad_oe[i]  = 1'b1;
						end else begin
							next_pad_out[i] = alt_data[i];
							next_pad_oe[i]  = alt_en[i];
						end
					end
					default: begin
						next_pad_out[i] = 1'b0;
						next_pad_oe[i]  = 1'b0;
					end
				endcase
			end
		end
		// pads outside the wake set never reach here
		next_wake_request = asleep & |(changed & is_input & wake_en & WAKE_MASK);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out      <= '0;
			pad_oe       <= '0;
			wake_request <= 1'b0;
		end else begin
			pad_out      <= next_pad_out;
			pad_oe       <= next_pad_oe;
			wake_request <= next_wake_request;
		end
	end
endmodule : gpio_status_unit
`default_nettype wire

/* File: test/gpio_status_unit_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// checker on the top ports
module gpio_status_unit_chk
	import gpio_pkg::*;
#(
	parameter int PADS = PAD_COUNT
) (
	input wire logic                clk,          // clock
	input wire logic                rst_n,        // reset
	input wire logic                wr,           // write strobe
	input wire logic                rd,           // read strobe
	input wire logic [gpio_pkg::DATA_W-1:0] rdata, // read data
	input wire logic [PADS-1:0]     pad_in,       // pad levels
	input wire logic [PADS-1:0]     pad_out,      // drive levels
	input wire logic [PADS-1:0]     pad_oe,       // drive enables
	input wire logic [PADS-1:0]     alt_data,     // alternate data
	input wire logic [PADS-1:0]     alt_en,       // alternate enable
	input wire logic                asleep,       // sleep
	input wire logic                temp_max,     // hot
	input wire logic                wake_request  // wake pulse
);
	import gpio_pkg::*;

	localparam logic [PADS-1:0] WMASK = PADS'((1 << WAKE_PAD_A) | (1 << WAKE_PAD_B) |
		(1 << WAKE_PAD_C) | (1 << WAKE_PAD_D));
	localparam logic [PADS-1:0] IMASK = PADS'(1 << IND_PAD);
	logic [3:0]      rst_cnt, next_rst_cnt, wk_cnt, next_wk_cnt, cz_cnt, next_cz_cnt;
	logic [PADS-1:0] pin_q, aen_q, adat_q;
	logic            temp_q;

	// ========================================
	// windows: cycles since reset, since a wake pad moved, since a drive cause
	always_comb begin
		next_rst_cnt = (rst_cnt == 4'hF) ? rst_cnt : rst_cnt + 4'h1;
		next_wk_cnt = (wk_cnt == 4'h0) ? 4'h0 : wk_cnt - 4'h1;
		next_cz_cnt = (cz_cnt == 4'h0) ? 4'h0 : cz_cnt - 4'h1;
		if (((pad_in ^ pin_q) & WMASK) != '0) next_wk_cnt = 4'h8;
		if (wr || temp_max != temp_q || alt_en != aen_q || alt_data != adat_q) next_cz_cnt = 4'h6;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_cnt <= 4'h0;
			wk_cnt <= 4'h0;
			cz_cnt <= 4'h0;
			pin_q <= '0;
			aen_q <= '0;
			adat_q <= '0;
			temp_q <= 1'b0;
		end else begin
			rst_cnt <= next_rst_cnt;
			wk_cnt <= next_wk_cnt;
			cz_cnt <= next_cz_cnt;
			pin_q <= pad_in;
			aen_q <= alt_en;
			adat_q <= alt_data;
			temp_q <= temp_max;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
		else $error("read data outside its cycle");
	chk_wake_pulse: assert property (wake_request |=> !wake_request)
		else $error("wake longer than one cycle");
	chk_wake_sleep: assert property (wake_request |-> asleep || $past(asleep))
		else $error("wake while awake");
	chk_wake_source: assert property (wake_request |-> wk_cnt != 4'h0)
		else $error("wake without wake pad activity");
	chk_ind_on_min: assert property ($rose(pad_out[IND_PAD]) |=> pad_out[IND_PAD] [*8])
		else $error("indicator on phase too short");
	chk_default_pads: assert property (rst_cnt == 4'h3 |-> pad_oe[IND_PAD] && pad_oe[BOOT_PAD]
		&& !pad_out[IND_PAD] && !pad_out[BOOT_PAD])
		else $error("default pads not driven low");
	chk_oe_cause: assert property (rst_cnt == 4'hF && pad_oe != $past(pad_oe) |-> cz_cnt != 4'h0)
		else $error("drive enable moved without cause");
	chk_out_cause: assert property (rst_cnt == 4'hF && ((pad_out ^ $past(pad_out)) & ~IMASK) != '0
		|-> cz_cnt != 4'h0)
		else $error("drive level moved without cause");
endmodule : gpio_status_unit_chk

bind gpio_status_unit gpio_status_unit_chk #(.PADS(PADS)) i_gpio_status_unit_chk (
	.clk(clk), .rst_n(rst_n), .wr(wr), .rd(rd), .rdata(rdata), .pad_in(pad_in),
	.pad_out(pad_out), .pad_oe(pad_oe), .alt_data(alt_data), .alt_en(alt_en),
	.asleep(asleep), .temp_max(temp_max), .wake_request(wake_request));
`default_nettype wire

/* File: test/pad_world.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// external logic on the pads
module pad_world #(
	parameter int PADS = 10
) (
	input wire logic [PADS-1:0] pad_out,   // module drive level
	input wire logic [PADS-1:0] pad_oe,    // module drive enable
	input wire logic [PADS-1:0] ext_level, // external device outputs
	output logic     [PADS-1:0] pad_in     // resolved wire level
);
	// push-pull drive wins both ways, so no pull-up is modelled
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : pad_world
`default_nettype wire

/* File: test/test_module_gpio_status_signals.sv */
`timescale 1ns/1ps
`default_nettype none
module test_module_gpio_status_signals;
	import gpio_pkg::*;
	localparam int          TCK = 4;
	localparam logic [31:0] CBASE = 32'h0001_0100;
	logic                 clk, rst_n, wr, rd, asleep, temp_max, wake_request;
	logic [ADDR_W-1:0]    addr;
	logic [DATA_W-1:0]    wdata, rdata;
	logic [PAD_COUNT-1:0] pad_in, pad_out, pad_oe, alt_data, alt_en, ext;
	int                   n_fail = 0, total_checks = 0, cyc = 0, n_wake = 0, n;

	gpio_status_unit #(.PADS(PAD_COUNT), .TICK_CYC(TCK)) i_gpio_status_unit (
		.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.alt_data(alt_data), .alt_en(alt_en), .asleep(asleep), .temp_max(temp_max),
		.wake_request(wake_request));
	pad_world #(.PADS(PAD_COUNT)) i_pad_world (
		.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext), .pad_in(pad_in));

	// ========================================
	// helpers
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chk1
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rchk
	// from off, so the pattern really changes and must restart lit
	task automatic blink(input dev_state_t st, input int on, input int off);
		// a lit phase that was just entered may not be cut shorter than 8 cycles
		tick(8);
		wreg(OFS_CTRL, CBASE);
		tick(4);
		wreg(OFS_CTRL, CBASE | 32'(st));
		tick(3);
		chk1(pad_out[IND_PAD], 1'b1);
		n = 0;
		while (pad_out[IND_PAD] === 1'b1 && n < 20000) begin
			tick(1);
			n++;
		end
		chk(32'(n >= on - 4 && n <= on + 4), 32'h1);
		n = 0;
		while (pad_out[IND_PAD] === 1'b0 && n < 20000) begin
			tick(1);
			n++;
		end
		chk(32'(n >= off - 4 && n <= off + 4), 32'h1);
	endtask : blink

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wake_request === 1'b1) n_wake <= n_wake + 1;
		if (cyc == 60000) begin
			n_fail++;
			close_out();
		end
	end

	// ========================================
	// sequence
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		asleep = 1'b0;
		temp_max = 1'b0;
		alt_data = '0;
		alt_en = '0;
		ext = 10'h204;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		tick(3);
		chk(32'(pad_oe), 32'h081);
		chk(32'(pad_out), 32'h0);
		rchk(OFS_MODE, 32'h0000_8002);
		rchk(OFS_CTRL, 32'h0001_0000);
		rchk(OFS_LEVEL, 32'h204);
		ext <= '0;
		tick(5);
		rchk(OFS_LEVEL, 32'h0);
		rchk(8'h40, 32'h0);
		wreg(OFS_MODE, 32'h0000_8806);
		wreg(OFS_OUT, 32'h2);
		alt_en <= 10'h020;
		alt_data <= 10'h020;
		tick(3);
		chk(32'(pad_oe), 32'h0A3);
		chk(32'(pad_out), 32'h022);
		wreg(OFS_OUT, 32'h0);
		alt_data <= '0;
		tick(3);
		chk(32'(pad_out), 32'h0);
		chk(32'(pad_oe), 32'h0A3);
		wreg(OFS_CTRL, CBASE);
		tick(3);
		chk1(pad_out[BOOT_PAD], 1'b1);
		temp_max <= 1'b1;
		tick(3);
		chk1(pad_oe[2], 1'b0);
		wreg(OFS_CTRL, 32'h0002_1100);
		tick(3);
		chk1(pad_out[2], 1'b1);
		chk1(pad_oe[2], 1'b1);
		temp_max <= 1'b0;
		wreg(OFS_CTRL, CBASE);
		wreg(OFS_EVT_EN, 32'h4);
		ext <= 10'h004;
		tick(6);
		rchk(OFS_EVENT, 32'h4);
		wreg(OFS_EVENT, 32'h4);
		rchk(OFS_EVENT, 32'h0);
		asleep <= 1'b1;
		wreg(OFS_WAKE_EN, 32'h3FF);
		rchk(OFS_WAKE_EN, 32'h099);
		for (int p = 2; p < 7; p++) begin
			n = n_wake;
			ext <= ext ^ (10'h1 << p);
			tick(8);
			chk(32'(n_wake - n), 32'(p == 3 || p == 4));
		end
		asleep <= 1'b0;
		n = n_wake;
		ext <= ext ^ 10'h008;
		tick(8);
		chk(32'(n_wake - n), 32'h0);
		wreg(OFS_CTRL, CBASE | 32'h4);
		tick(3000);
		chk1(pad_out[IND_PAD], 1'b1);
		wreg(OFS_CTRL, CBASE);
		tick(3);
		chk1(pad_out[IND_PAD], 1'b0);
		blink(DEV_SEARCH, FAST_ON_MS * TCK, (FAST_PERIOD_MS - FAST_ON_MS) * TCK);
		blink(DEV_UNREG, FAST_ON_MS * TCK, (FAST_PERIOD_MS - FAST_ON_MS) * TCK);
		blink(DEV_TURNING_OFF, FAST_ON_MS * TCK, (FAST_PERIOD_MS - FAST_ON_MS) * TCK);
		blink(DEV_REGISTERED, SLOW_ON_MS * TCK, (SLOW_PERIOD_MS - SLOW_ON_MS) * TCK);
		close_out();
	end
endmodule : test_module_gpio_status_signals
`default_nettype wire
